/* File: framer_pkg.sv */
// Constants, register map and carrier types for the transport payload framer.
// Assumes a 32-bit AXI4-Lite register bus and byte-wide payload streams.
package framer_pkg;

    // Packet type codes, they select the payload layout
    localparam logic [1:0]  ACK_PACKET_TYPE        = 2'h0;
    localparam logic [1:0]  APP_PACKET_TYPE        = 2'h1;
    localparam logic [1:0]  SIGNED_APP_PACKET_TYPE = 2'h2;

    // Register byte offsets
    localparam logic [7:0]  CTRL_OFF     = 8'h00;
    localparam logic [7:0]  STATUS_OFF   = 8'h04;
    localparam logic [7:0]  MASK_OFF     = 8'h08;
    localparam logic [7:0]  LAST_ACK_OFF = 8'h0C;
    localparam logic [7:0]  SIG_INFO_OFF = 8'h10;
    localparam logic [7:0]  RECORD_OFF   = 8'h14;
    localparam logic [7:0]  SMS_OFF      = 8'h18;
    localparam logic [7:0]  ACK_OUT_OFF  = 8'h1C;

    // Status and mask bit positions
    localparam int          ST_FRAME = 0;
    localparam int          ST_CRC   = 1;
    localparam int          ST_SIG   = 2;
    localparam int          ST_SMS   = 3;
    localparam int          ST_ACKED = 4;
    localparam int          ST_SHORT = 5;
    localparam int          ST_W     = 6;
    localparam int          CTRL_EN_BIT = 0;

    // Limits and codes
    localparam logic [15:0] SIG_MAX      = 16'h0200;
    localparam logic [15:0] SMS_MAX      = 16'h008C;
    localparam logic [15:0] MIN_FRAME    = 16'h0003;
    localparam logic [15:0] CSUM_BYTES   = 16'h0002;
    localparam logic [15:0] CRC_INIT     = 16'hFFFF;
    localparam logic [15:0] CRC_POLY     = 16'h1021;
    localparam logic [7:0]  SMS_DCS_8BIT = 8'h04;
    localparam logic [7:0]  RESULT_OK    = 8'h00;
    localparam logic [7:0]  RESULT_CRC   = 8'h01;
    localparam logic [7:0]  RESULT_FMT   = 8'h02;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // Field positions inside the payload
    localparam logic [15:0] ID_LO_IDX  = 16'h0000;
    localparam logic [15:0] ID_HI_IDX  = 16'h0001;
    localparam logic [15:0] ACK_PR_IDX = 16'h0002;

    // Outgoing acknowledgement byte order
    localparam logic [2:0]  TX_PID_LO = 3'h0;
    localparam logic [2:0]  TX_PID_HI = 3'h1;
    localparam logic [2:0]  TX_PR     = 3'h2;
    localparam logic [2:0]  TX_CRC_LO = 3'h3;
    localparam logic [2:0]  TX_CRC_HI = 3'h4;

    typedef enum logic [1:0] {RX_HEAD, RX_SIG, RX_RECORDS} rx_state_t;
    typedef enum logic       {TX_IDLE, TX_SEND} tx_state_t;

    typedef struct packed {
        logic [1:0]  ptype;
        logic [15:0] packet_identifier;
        logic [7:0]  data;
        logic        last;
    } rx_byte_t;

    typedef struct packed {
        logic [7:0]  data;
        logic        last;
    } tx_byte_t;

    typedef struct packed {
        logic            awready;
        logic            wready;
        logic            arready;
        logic            aw_hold;
        logic [7:0]      aw_addr;
        logic            w_hold;
        logic [31:0]     w_data;
        logic [3:0]      w_strb;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            rvalid;
        logic [31:0]     rdata;
        logic [1:0]      rresp;
        logic            ctrl_en;
        logic [ST_W-1:0] status;
        logic [ST_W-1:0] mask;
        logic            irq;
        rx_state_t       rx_st;
        logic            rx_ready;
        logic [15:0]     rx_cnt;
        logic [1:0]      rx_type;
        logic [15:0]     rx_pid;
        logic [7:0]      hold0;
        logic [7:0]      hold1;
        logic [15:0]     crc;
        logic [15:0]     sig_len;
        logic [15:0]     sig_cnt;
        logic [15:0]     last_id;
        logic [7:0]      last_pr;
        logic [15:0]     rec_cnt;
        logic            ack_pend;
        logic [15:0]     ack_pid;
        logic [7:0]      ack_pr;
        tx_state_t       tx_st;
        logic [2:0]      tx_idx;
        logic [15:0]     tx_crc;
        logic            tx_valid;
        tx_byte_t        tx;
        logic [15:0]     sms_len;
        logic            sms_ok;
    } state_t;

endpackage : framer_pkg

/* File: transport_ack_signed_framer.sv */
// Transport payload framer: parses incoming payloads, answers with acknowledgements.
// Assumes AXI4-Lite master, byte stream source and sink on the same aclk.
//
// Contract
// - Acknowledgement payload starts with two-byte identifier of the acknowledged packet.
// - One-byte processing result follows the acknowledged identifier.
// - Service records follow fixed fields back to back, zero or more.
// - Every unsigned or signed application packet gets an acknowledgement with its identifier.
// - Signed payload starts with two-byte signature length.
// - Signature of 0 to 512 bytes follows, then service records.
// - Short message backup link uses 8-bit data encoding.
// - Short message carries packets as binary user data in PDU mode.
// - Type 0 acknowledgement, 1 application, 2 signed application selects layout.
// - Non-empty payload is followed by CRC-16 CCITT checked into result.
`timescale 1ns/1ps
module transport_ack_signed_framer (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [7:0]          awaddr,
    input  wire logic                awvalid,
    output logic                     awready,
    input  wire logic [31:0]         wdata,
    input  wire logic [3:0]          wstrb,
    input  wire logic                wvalid,
    output logic                     wready,
    output logic [1:0]               bresp,
    output logic                     bvalid,
    input  wire logic                bready,
    input  wire logic [7:0]          araddr,
    input  wire logic                arvalid,
    output logic                     arready,
    output logic [31:0]              rdata,
    output logic [1:0]               rresp,
    output logic                     rvalid,
    input  wire logic                rready,
    input  wire framer_pkg::rx_byte_t rx_byte,
    input  wire logic                rx_valid,
    output logic                     rx_ready,
    output framer_pkg::tx_byte_t     tx_byte,
    output logic                     tx_valid,
    input  wire logic                tx_ready,
    output logic                     sms_dcs_ok,
    output logic                     irq
);
    import framer_pkg::*;

    state_t      s_reg;
    state_t      s_next;
    logic        take;
    logic        do_wr;
    logic [1:0]  type_eff;
    logic [15:0] pid_eff;

    function automatic logic [15:0] crc_step(input logic [15:0] c_in, input logic [7:0] d);
        logic [15:0] c;
        logic        fb;
        c = c_in;
        for (int i = 7; i >= 0; i--) begin
            fb = c[15] ^ d[i];
            c  = {c[14:0], 1'b0};
            if (fb) begin
                c = c ^ CRC_POLY;
            end
        end
        return c;
    endfunction : crc_step

    assign take     = rx_valid && s_reg.rx_ready;
    assign do_wr    = s_reg.aw_hold && s_reg.w_hold && !s_reg.bvalid;
    assign type_eff = (s_reg.rx_cnt == ID_LO_IDX) ? rx_byte.ptype : s_reg.rx_type;
    assign pid_eff  = (s_reg.rx_cnt == ID_LO_IDX) ? rx_byte.packet_identifier : s_reg.rx_pid;

    always_comb begin
        logic [ST_W-1:0] ev;
        logic [ST_W-1:0] clr;
        logic [15:0]     cnt_new;
        logic [15:0]     len_new;
        logic [7:0]      pr;
        logic            short_f;
        logic            crc_ok;
        ev      = '0;
        clr     = '0;
        cnt_new = '0;
        len_new = '0;
        pr      = RESULT_OK;
        short_f = 1'b0;
        crc_ok  = 1'b0;
        s_next  = s_reg;

        // Write address and data may arrive in either order
        if (s_reg.awready && awvalid) begin
            s_next.aw_hold = 1'b1;
            s_next.aw_addr = awaddr;
        end
        if (s_reg.wready && wvalid) begin
            s_next.w_hold = 1'b1;
            s_next.w_data = wdata;
            s_next.w_strb = wstrb;
        end
        if (s_reg.bvalid && bready) begin
            s_next.bvalid = 1'b0;
        end
        if (do_wr) begin
            s_next.aw_hold = 1'b0;
            s_next.w_hold  = 1'b0;
            s_next.bvalid  = 1'b1;
            s_next.bresp   = RESP_OKAY;
            case (s_reg.aw_addr)
                CTRL_OFF: begin
                    if (s_reg.w_strb[0]) begin
                        s_next.ctrl_en = s_reg.w_data[CTRL_EN_BIT];
                    end
                end
                STATUS_OFF: begin
                    clr = s_reg.w_data[ST_W-1:0] & {ST_W{s_reg.w_strb[0]}};
                end
                MASK_OFF: begin
                    if (s_reg.w_strb[0]) begin
                        s_next.mask = s_reg.w_data[ST_W-1:0];
                    end
                end
                SMS_OFF: begin
                    // Length check needs both low lanes; a partial write is ignored
                    if (s_reg.w_strb[1:0] == 2'h3) begin
                        s_next.sms_len = s_reg.w_data[15:0];
                        s_next.sms_ok  = (s_reg.w_data[15:0] <= SMS_MAX);
                        ev[ST_SMS]     = (s_reg.w_data[15:0] > SMS_MAX);
                    end
                end
                LAST_ACK_OFF, SIG_INFO_OFF, RECORD_OFF, ACK_OUT_OFF: begin
                end
                default: begin
                    s_next.bresp = RESP_SLVERR;
                end
            endcase
        end

        if (s_reg.rvalid && rready) begin
            s_next.rvalid = 1'b0;
        end
        if (s_reg.arready && arvalid) begin
            s_next.rvalid = 1'b1;
            s_next.rresp  = RESP_OKAY;
            case (araddr)
                CTRL_OFF:     s_next.rdata = {31'h0, s_reg.ctrl_en};
                STATUS_OFF:   s_next.rdata = {26'h0, s_reg.status};
                MASK_OFF:     s_next.rdata = {26'h0, s_reg.mask};
                LAST_ACK_OFF: s_next.rdata = {8'h00, s_reg.last_pr, s_reg.last_id};
                SIG_INFO_OFF: s_next.rdata = {16'h0000, s_reg.sig_len};
                RECORD_OFF:   s_next.rdata = {16'h0000, s_reg.rec_cnt};
                // Encoding byte is fixed: binary PDU user data only
                SMS_OFF:      s_next.rdata = {SMS_DCS_8BIT, 7'h00, s_reg.sms_ok, s_reg.sms_len};
                ACK_OUT_OFF:  s_next.rdata = {7'h00, s_reg.ack_pend, s_reg.ack_pr, s_reg.ack_pid};
                default: begin
                    s_next.rdata = 32'h0000_0000;
                    s_next.rresp = RESP_SLVERR;
                end
            endcase
        end

        // Receive side; checksum trails two bytes behind the data
        if (take) begin
            cnt_new        = s_reg.rx_cnt + 16'h0001;
            s_next.rx_cnt  = cnt_new;
            s_next.rx_type = type_eff;
            s_next.rx_pid  = pid_eff;
            s_next.hold0   = rx_byte.data;
            s_next.hold1   = s_reg.hold0;
            if (s_reg.rx_cnt == ID_LO_IDX) begin
                s_next.crc     = CRC_INIT;
                s_next.rec_cnt = '0;
                s_next.sig_cnt = '0;
            end else if (s_reg.rx_cnt > ID_HI_IDX) begin
                s_next.crc = crc_step(s_reg.crc, s_reg.hold1);
            end
            case (s_reg.rx_st)
                RX_HEAD: begin
                    case (type_eff)
                        ACK_PACKET_TYPE: begin
                            if (s_reg.rx_cnt == ID_LO_IDX) begin
                                s_next.last_id[7:0] = rx_byte.data;
                            end else if (s_reg.rx_cnt == ID_HI_IDX) begin
                                s_next.last_id[15:8] = rx_byte.data;
                            end else begin
                                s_next.last_pr = rx_byte.data;
                                s_next.rx_st   = RX_RECORDS;
                            end
                        end
                        SIGNED_APP_PACKET_TYPE: begin
                            if (s_reg.rx_cnt == ID_LO_IDX) begin
                                s_next.sig_len = {8'h00, rx_byte.data};
                            end else begin
                                len_new        = {rx_byte.data, s_reg.sig_len[7:0]};
                                s_next.sig_len = len_new;
                                ev[ST_SIG]     = (len_new > SIG_MAX);
                                s_next.rx_st   = (len_new == '0) ? RX_RECORDS : RX_SIG;
                            end
                        end
                        default: begin
                            s_next.rec_cnt = 16'h0001;
                            s_next.rx_st   = RX_RECORDS;
                        end
                    endcase
                end
                RX_SIG: begin
                    s_next.sig_cnt = s_reg.sig_cnt + 16'h0001;
                    if (s_next.sig_cnt == s_reg.sig_len) begin
                        s_next.rx_st = RX_RECORDS;
                    end
                end
                RX_RECORDS: begin
                    s_next.rec_cnt = s_reg.rec_cnt + 16'h0001;
                end
                default: begin
                    s_next.rx_st = RX_HEAD;
                end
            endcase
            if (rx_byte.last) begin
                short_f = (cnt_new < MIN_FRAME);
                crc_ok  = (s_next.crc == {rx_byte.data, s_reg.hold0});
                // Checksum bytes were counted as record bytes
                s_next.rec_cnt = (s_next.rec_cnt >= CSUM_BYTES) ?
                                 (s_next.rec_cnt - CSUM_BYTES) : 16'h0000;
                pr = short_f ? RESULT_FMT : (crc_ok ? RESULT_OK : RESULT_CRC);
                ev[ST_SHORT] = short_f;
                ev[ST_CRC]   = !short_f && !crc_ok;
                ev[ST_FRAME] = 1'b1;
                if (type_eff == APP_PACKET_TYPE || type_eff == SIGNED_APP_PACKET_TYPE) begin
                    s_next.ack_pend = 1'b1;
                    s_next.ack_pid  = pid_eff;
                    s_next.ack_pr   = pr;
                end
                s_next.rx_cnt = '0;
                s_next.rx_st  = RX_HEAD;
            end
        end

        // Acknowledgement transmitter: id low, id high, result, checksum low, high
        case (s_reg.tx_st)
            TX_IDLE: begin
                if (s_reg.ack_pend) begin
                    s_next.tx_st    = TX_SEND;
                    s_next.tx_idx   = TX_PID_LO;
                    s_next.tx_valid = 1'b1;
                    s_next.tx       = '{data: s_reg.ack_pid[7:0], last: 1'b0};
                    s_next.tx_crc   = crc_step(CRC_INIT, s_reg.ack_pid[7:0]);
                end
            end
            TX_SEND: begin
                if (tx_ready) begin
                    s_next.tx_idx = s_reg.tx_idx + 3'h1;
                    case (s_reg.tx_idx)
                        TX_PID_LO: begin
                            s_next.tx.data = s_reg.ack_pid[15:8];
                            s_next.tx_crc  = crc_step(s_reg.tx_crc, s_reg.ack_pid[15:8]);
                        end
                        TX_PID_HI: begin
                            s_next.tx.data = s_reg.ack_pr;
                            s_next.tx_crc  = crc_step(s_reg.tx_crc, s_reg.ack_pr);
                        end
                        TX_PR: begin
                            s_next.tx.data = s_reg.tx_crc[7:0];
                        end
                        TX_CRC_LO: begin
                            s_next.tx.data = s_reg.tx_crc[15:8];
                            s_next.tx.last = 1'b1;
                        end
                        default: begin
                            s_next.tx_st    = TX_IDLE;
                            s_next.tx_valid = 1'b0;
                            s_next.tx       = '0;
                            s_next.ack_pend = 1'b0;
                            ev[ST_ACKED]    = 1'b1;
                        end
                    endcase
                end
            end
            default: begin
                s_next.tx_st = TX_IDLE;
            end
        endcase

        // Set wins over a clear in the same cycle
        s_next.status   = (s_reg.status & ~clr) | ev;
        s_next.irq      = |(s_next.status & s_next.mask);
        s_next.awready  = !s_next.aw_hold;
        s_next.wready   = !s_next.w_hold;
        s_next.arready  = !s_next.rvalid;
        // Stalling input until the answer is out keeps every application packet answered
        s_next.rx_ready = s_next.ctrl_en && !s_next.ack_pend;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign awready    = s_reg.awready;
    assign wready     = s_reg.wready;
    assign bvalid     = s_reg.bvalid;
    assign bresp      = s_reg.bresp;
    assign arready    = s_reg.arready;
    assign rvalid     = s_reg.rvalid;
    assign rdata      = s_reg.rdata;
    assign rresp      = s_reg.rresp;
    assign rx_ready   = s_reg.rx_ready;
    assign tx_byte    = s_reg.tx;
    assign tx_valid   = s_reg.tx_valid;
    assign sms_dcs_ok = s_reg.sms_ok;
    assign irq        = s_reg.irq;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_tx_pid;
        tx_valid && s_reg.tx_idx == TX_PID_LO |-> tx_byte.data == s_reg.ack_pid[7:0];
    endproperty
    a_tx_pid: assert property (p_tx_pid) else $error("ack id low byte wrong");
    property p_tx_pid_hi;
        tx_valid && s_reg.tx_idx == TX_PID_HI |-> tx_byte.data == s_reg.ack_pid[15:8];
    endproperty
    a_tx_pid_hi: assert property (p_tx_pid_hi) else $error("ack id high byte wrong");
    property p_tx_pr;
        tx_valid && tx_ready && s_reg.tx_idx == TX_PID_HI |=>
            tx_valid && tx_byte.data == s_reg.ack_pr && !tx_byte.last;
    endproperty
    a_tx_pr: assert property (p_tx_pr) else $error("result byte wrong");
    property p_rec_count;
        take && s_reg.rx_st == RX_RECORDS && !rx_byte.last |=>
            s_reg.rec_cnt == $past(s_reg.rec_cnt) + 16'h0001;
    endproperty
    a_rec_count: assert property (p_rec_count) else $error("record count stuck");
    property p_ack_owed;
        take && rx_byte.last && (type_eff == APP_PACKET_TYPE ||
            type_eff == SIGNED_APP_PACKET_TYPE) |=>
            s_reg.ack_pend && s_reg.ack_pid == $past(pid_eff) && !rx_ready;
    endproperty
    a_ack_owed: assert property (p_ack_owed) else $error("ack not queued");
    property p_ack_start;
        s_reg.ack_pend && s_reg.tx_st == TX_IDLE |=> tx_valid && !tx_byte.last;
    endproperty
    a_ack_start: assert property (p_ack_start) else $error("ack not started");
    property p_sig_limit;
        take && s_reg.rx_st == RX_HEAD && type_eff == SIGNED_APP_PACKET_TYPE &&
            s_reg.rx_cnt == ID_HI_IDX && {rx_byte.data, s_reg.sig_len[7:0]} > SIG_MAX
            |=> s_reg.status[ST_SIG];
    endproperty
    a_sig_limit: assert property (p_sig_limit) else $error("long signature missed");
    property p_no_ack_for_ack;
        take && rx_byte.last && type_eff == ACK_PACKET_TYPE |=> !s_reg.ack_pend;
    endproperty
    a_no_ack_for_ack: assert property (p_no_ack_for_ack) else $error("ack answered");
    property p_crc_err;
        take && rx_byte.last && s_reg.rx_cnt >= ID_HI_IDX + 16'h0001 &&
            s_next.crc != {rx_byte.data, s_reg.hold0} |=> s_reg.status[ST_CRC];
    endproperty
    a_crc_err: assert property (p_crc_err) else $error("checksum error missed");
    property p_sms_limit;
        do_wr && s_reg.aw_addr == SMS_OFF && s_reg.w_strb[1:0] == 2'h3 &&
            s_reg.w_data[15:0] > SMS_MAX |=> s_reg.status[ST_SMS] && !sms_dcs_ok;
    endproperty
    a_sms_limit: assert property (p_sms_limit) else $error("long sms accepted");
    property p_bresp_hold;
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");
    property p_irq;
        irq == |(s_reg.status & s_reg.mask);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt level wrong");

    c_ack_sent: cover property (tx_valid && tx_ready && tx_byte.last);
    c_crc_err: cover property (s_reg.status[ST_CRC]);
    c_signed: cover property (s_reg.rx_st == RX_SIG ##1 s_reg.rx_st == RX_RECORDS);
    c_sms_long: cover property (s_reg.status[ST_SMS]);

endmodule : transport_ack_signed_framer

/* File: remote_platform.sv */
// Far-side sink that takes the acknowledgement stream.
// Assumes the framer's aclk; slow makes it stall every other cycle.
`timescale 1ns/1ps
module remote_platform (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire framer_pkg::tx_byte_t tx_byte,
    input  wire logic                 tx_valid,
    input  wire logic                 slow,
    output logic                      tx_ready
);
    import framer_pkg::*;
    // Last flag kept beside each byte so the frame end can be judged
    logic [8:0] got[$];
    // Stalls show whether each byte is held until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) tx_ready <= 1'b0;
        else tx_ready <= slow ? !tx_ready : 1'b1;
        if (aresetn && tx_valid && tx_ready) got.push_back({tx_byte.last, tx_byte.data});
    end
endmodule : remote_platform

/* File: test_transport_ack_signed_framer.sv */
// Self-checking bench for the transport payload framer.
// Assumes framer_pkg and the remote_platform sink model.
`timescale 1ns/1ps
module test_transport_ack_signed_framer;
    import framer_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, rx_valid = 1'b0, slow = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [3:0] wstrb = 4'hF;
    rx_byte_t rx_byte = '0;
    tx_byte_t tx_byte;
    logic awready, wready, bvalid, arready, rvalid, rx_ready, tx_valid, tx_ready;
    logic sms_dcs_ok, irq;
    logic [1:0] bresp, rresp, r;
    logic [7:0] e[$];
    int bad_count = 0, check_count = 0, n0;
    transport_ack_signed_framer DUT (.*);
    remote_platform rp (.*);
    always #4 aclk = ~aclk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Handshakes judged at the falling edge, acted on at the next rising one
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic aw, w, b;
        int n;
        aw = 0; w = 0; b = 0; n = 0;
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        while (!b && n < 200) begin
            @(negedge aclk);
            aw |= awready === 1'b1; w |= wready === 1'b1; b = bvalid === 1'b1; n++; r = bresp;
            @(posedge aclk);
            if (aw && awvalid) awvalid <= 1'b0;
            if (w && wvalid) wvalid <= 1'b0;
        end
        // Ready stays up between writes; each call drives it high again
        chk(b ? r : 2'h3, RESP_OKAY);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic ar, g;
        int n;
        ar = 0; g = 0; n = 0;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        while (!g && n < 200) begin
            @(negedge aclk);
            ar |= arready === 1'b1; g = rvalid === 1'b1; d = rdata; r = rresp; n++;
            @(posedge aclk);
            if (ar && arvalid) arvalid <= 1'b0;
        end
        if (!g) bad_count++;
    endtask : rd
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        rd(a);
        chk(d & m, x);
        chk(r, RESP_OKAY);
    endtask : rdc
    function automatic logic [15:0] crc(input logic [7:0] p[$]);
        logic [15:0] c;
        c = CRC_INIT;
        foreach (p[i]) begin
            c ^= {p[i], 8'h00};
            repeat (8) c = c[15] ? (c << 1) ^ CRC_POLY : c << 1;
        end
        return c;
    endfunction : crc
    // Sends payload plus checksum, low byte first; bad spoils the checksum
    task automatic frame(input logic [1:0] t, input logic [15:0] id, input logic [7:0] p[$],
                         input bit bad);
        logic [15:0] c;
        int n;
        c = crc(p) ^ {15'h0, bad};
        p.push_back(c[7:0]);
        p.push_back(c[15:8]);
        foreach (p[i]) begin
            rx_byte <= '{t, id, p[i], i == p.size() - 1}; rx_valid <= 1'b1; n = 0;
            do begin @(negedge aclk); n++; end while (rx_ready !== 1'b1 && n < 50);
            @(posedge aclk);
        end
        rx_valid <= 1'b0; n0 = rp.got.size(); n = 0;
        repeat (3) @(posedge aclk);
        do begin @(negedge aclk); n++; end while (rx_ready !== 1'b1 && n < 100);
        @(posedge aclk);
    endtask : frame
    // Level looked at mid-cycle, then back on the rising edge for the next request
    task automatic irq_is(input logic v);
        @(negedge aclk);
        chk(irq, v);
        @(posedge aclk);
    endtask : irq_is
    task automatic ack(input logic [15:0] id, input logic [7:0] res);
        logic [7:0] x[$];
        logic [15:0] c;
        x = {id[7:0], id[15:8], res};
        c = crc(x);
        x.push_back(c[7:0]);
        x.push_back(c[15:8]);
        chk(rp.got.size(), n0 + 5);
        foreach (x[i]) chk(rp.got[n0 + i], {i == x.size() - 1, x[i]});
    endtask : ack
    task automatic t_regs;
        rdc(STATUS_OFF, 32'hFFFFFFFF, 32'h0);
        rd(8'h20);
        chk(d, 32'h0);
        chk(r, RESP_SLVERR);
        wr(CTRL_OFF, 32'h1);
        wr(MASK_OFF, 32'h3F);
    endtask : t_regs
    task automatic t_app;
        frame(APP_PACKET_TYPE, 16'h1234, {8'hA1, 8'hB2}, 0);
        ack(16'h1234, RESULT_OK);
        rdc(RECORD_OFF, 32'hFFFF, 32'h2);
        irq_is(1'b1);
    endtask : t_app
    task automatic t_bad;
        slow <= 1'b1;
        frame(APP_PACKET_TYPE, 16'hBEEF, {8'h01}, 1);
        ack(16'hBEEF, RESULT_CRC);
        slow <= 1'b0;
    endtask : t_bad
    task automatic t_sig;
        frame(SIGNED_APP_PACKET_TYPE, 16'h00FF, {8'h02, 8'h00, 8'h5A, 8'hC3, 8'h77}, 0);
        ack(16'h00FF, RESULT_OK);
        rdc(SIG_INFO_OFF, 32'hFFFF, 32'h2);
        frame(SIGNED_APP_PACKET_TYPE, 16'h0C01, {8'h01, 8'h02}, 0);
        ack(16'h0C01, RESULT_OK);
        rdc(STATUS_OFF, 32'h4, 32'h4);
    endtask : t_sig
    task automatic t_ack0;
        frame(ACK_PACKET_TYPE, 16'h0001, {8'h34, 8'h12, 8'h01}, 0);
        chk(rp.got.size(), n0);
        rdc(LAST_ACK_OFF, 32'hFFFFFFFF, 32'h00011234);
    endtask : t_ack0
    task automatic t_short;
        frame(APP_PACKET_TYPE, 16'h0042, e, 0);
        ack(16'h0042, RESULT_FMT);
    endtask : t_short
    task automatic t_sms;
        wr(SMS_OFF, 32'h0000_008C);
        rdc(SMS_OFF, 32'hFFFFFFFF, {SMS_DCS_8BIT, 8'h01, 16'h008C});
        chk(sms_dcs_ok, 1'b1);
        wr(SMS_OFF, 32'h0000_008D);
        rdc(SMS_OFF, 32'hFFFFFFFF, {SMS_DCS_8BIT, 8'h00, 16'h008D});
        chk(sms_dcs_ok, 1'b0);
    endtask : t_sms
    task automatic t_irq;
        rdc(STATUS_OFF, 32'h3E, 32'h3E);
        wr(STATUS_OFF, 32'h3F);
        wr(MASK_OFF, 32'h0);
        wr(SMS_OFF, 32'h0000_00C8);
        irq_is(1'b0);
        wr(MASK_OFF, 32'h8);
        irq_is(1'b1);
        wr(STATUS_OFF, 32'h8);
        irq_is(1'b0);
    endtask : t_irq
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs; t_app; t_bad; t_sig; t_ack0; t_short; t_sms; t_irq;
        wrap_up;
    end
    // Whole run needs a few hundred cycles at most
    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        wrap_up;
    end
endmodule : test_transport_ack_signed_framer
